// file: rtl/sdl_pkg.sv
// Package for the strap default loader: port count, register positions,
// reset values and the carrier structs.
// Assumes a single 100 MHz clock domain and eight PHY ports.
package sdl_pkg;

   // ----------------------------------------------------------------
   // Geometry and timing
   // ----------------------------------------------------------------
   localparam int PORT_COUNT = 8;
   localparam int PORT_IDX_W = 3;
   localparam real CLK_PERIOD_NS = 10.0;
   localparam int SYNC_STAGES = 3;
   // Three synchroniser stages plus one agreement stage must fill before
   // the filtered pin level is meaningful.
   localparam logic [2:0] SETTLE_CYCLES = 3'h4;

   // ----------------------------------------------------------------
   // Management register positions
   // ----------------------------------------------------------------
   localparam logic [4:0] REG_PORT_CFG = 5'h10;
   localparam int BIT_MEDIA_FIBER = 0;
   localparam logic [4:0] REG_RX_FIFO = 5'h12;
   localparam int BIT_RX_DEPTH_HI = 15;
   localparam int BIT_RX_DEPTH_LO = 14;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic RST_MEDIA_FIBER = 1'h0;
   localparam logic [1:0] RST_RX_DEPTH = 2'h0;
   localparam logic [2:0] RST_SETTLE_CNT = 3'h0;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      SDL_WAIT = 3'h1,
      SDL_LOAD = 3'h2,
      SDL_RUN  = 3'h4
   } sdl_state_e;

   typedef struct packed {
      logic mediaFiber;
      logic [1:0] rxDepth;
   } sdl_port_cfg_s;

   typedef struct packed {
      logic wrEn;
      logic [PORT_IDX_W-1:0] port;
      logic [4:0] regAddr;
      logic [15:0] data;
   } sdl_mgmt_s;

endpackage

// file: rtl/sdl_pin_sync.sv
// Three-stage synchroniser with agreement filter for strap pins.
// Assumes pins are asynchronous to mclk.
`timescale 1ns/1ps
module sdl_pin_sync #(
   parameter int WIDTH = 1
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic [WIDTH-1:0] pinIn,
   output logic [WIDTH-1:0] stable
);

   logic [WIDTH-1:0] s1_r;
   logic [WIDTH-1:0] s2_r;
   logic [WIDTH-1:0] s3_r;
   logic [WIDTH-1:0] stable_r;
   logic [WIDTH-1:0] stable_nxt;

   // ----------------------------------------------------------------
   // Agreement filter
   // ----------------------------------------------------------------
   // Only the second and third stages are compared; the first stage may be
   // metastable and is read by the second stage alone.
   genvar g;
   generate
      for (g = 0; g < WIDTH; g++) begin : gBit
         always_comb begin
            stable_nxt[g] = (s2_r[g] == s3_r[g]) ? s3_r[g] : stable_r[g];
         end
      end
   endgenerate

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
         stable_r <= '0;
      end else begin
         s1_r <= pinIn;
         s2_r <= s1_r;
         s3_r <= s2_r;
         stable_r <= stable_nxt;
      end
   end

   assign stable = stable_r;

endmodule // sdl_pin_sync

// file: rtl/strap_default_loader.sv
// Strap default loader: catches the media and receive FIFO depth straps
// after reset and presets the per-port configuration bits.
// Assumes board pull resistors on the shared pins and a management write
// port driven from logic on mclk.
//
// Operation
// - Media strap copied to 16.0 every port.
// - Loaded bits stay readable and writable afterward.
// - Strap level picks twisted-pair or fiber globally.
// - FIFO straps loaded into 18.15:14 every port.
// - Receive-error pins port 5/4 undriven during reset.
// - Missing pull-up reads low, low default.
`timescale 1ns/1ps
module strap_default_loader (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic globalMediaSelectStrap,
   input wire logic rxDepthStrapHi,
   input wire logic rxDepthStrapLo,
   input wire logic [1:0] rxErrCore,
   output logic [1:0] rxErrPinOut,
   output logic [1:0] rxErrPinOe,
   input wire sdl_pkg::sdl_mgmt_s mgmt,
   output sdl_pkg::sdl_port_cfg_s [sdl_pkg::PORT_COUNT-1:0] portCfg
);

   // ----------------------------------------------------------------
   // Strap pin synchronisers
   // ----------------------------------------------------------------
   logic [2:0] strapStable;
   logic mediaStable;
   logic [1:0] depthStable;

   sdl_pin_sync #(.WIDTH(3)) uSync (
      .mclk(mclk),
      .nrst(nrst),
      .pinIn({globalMediaSelectStrap, rxDepthStrapHi, rxDepthStrapLo}),
      .stable(strapStable)
   );

   assign mediaStable = strapStable[2];
   assign depthStable = strapStable[1:0];

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   sdl_pkg::sdl_state_e state_r;
   sdl_pkg::sdl_state_e state_nxt;
   logic [2:0] settleCnt_r;
   logic [2:0] settleCnt_nxt;

   // The straps are taken exactly once, after the synchroniser has filled,
   // so a pin that toggles later as a receive-error output is never seen.
   always_comb begin
      state_nxt = state_r;
      settleCnt_nxt = settleCnt_r;
      unique case (state_r)
         sdl_pkg::SDL_WAIT: begin
            settleCnt_nxt = settleCnt_r + 3'h1;
            if (settleCnt_r == sdl_pkg::SETTLE_CYCLES - 3'h1) begin
               state_nxt = sdl_pkg::SDL_LOAD;
            end
         end
         sdl_pkg::SDL_LOAD: begin
            state_nxt = sdl_pkg::SDL_RUN;
         end
         sdl_pkg::SDL_RUN: begin
            state_nxt = sdl_pkg::SDL_RUN;
         end
         default: begin
            state_nxt = sdl_pkg::SDL_WAIT;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         state_r <= sdl_pkg::SDL_WAIT;
         settleCnt_r <= sdl_pkg::RST_SETTLE_CNT;
      end else begin
         state_r <= state_nxt;
         settleCnt_r <= settleCnt_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Shared receive-error pins
   // ----------------------------------------------------------------
   logic [1:0] rxErrOut_r;
   logic [1:0] rxErrOut_nxt;
   logic [1:0] rxErrOe_r;
   logic [1:0] rxErrOe_nxt;

   // The pins stay released until the straps are held, so the board pulls
   // alone set their level while the capture is pending.
   always_comb begin
      rxErrOe_nxt = (state_r == sdl_pkg::SDL_WAIT) ? 2'h0 : 2'h3;
      rxErrOut_nxt = (state_r == sdl_pkg::SDL_RUN) ? rxErrCore : 2'h0;
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         rxErrOe_r <= 2'h0;
         rxErrOut_r <= 2'h0;
      end else begin
         rxErrOe_r <= rxErrOe_nxt;
         rxErrOut_r <= rxErrOut_nxt;
      end
   end

   assign rxErrPinOut = rxErrOut_r;
   assign rxErrPinOe = rxErrOe_r;

   // ----------------------------------------------------------------
   // Per-port configuration bits
   // ----------------------------------------------------------------
   sdl_pkg::sdl_port_cfg_s [sdl_pkg::PORT_COUNT-1:0] cfg_r;
   sdl_pkg::sdl_port_cfg_s [sdl_pkg::PORT_COUNT-1:0] cfg_nxt;

   // Writes arriving before the load are dropped; the load would overwrite
   // them anyway, and dropping them keeps the outcome unambiguous.
   genvar p;
   generate
      for (p = 0; p < sdl_pkg::PORT_COUNT; p++) begin : gPort
         always_comb begin
            cfg_nxt[p] = cfg_r[p];
            if (state_r == sdl_pkg::SDL_LOAD) begin
               cfg_nxt[p].mediaFiber = mediaStable;
               cfg_nxt[p].rxDepth = depthStable;
            end else if (state_r == sdl_pkg::SDL_RUN && mgmt.wrEn &&
                         int'(mgmt.port) == p) begin
               if (mgmt.regAddr == sdl_pkg::REG_PORT_CFG) begin
                  cfg_nxt[p].mediaFiber = mgmt.data[sdl_pkg::BIT_MEDIA_FIBER];
               end
               if (mgmt.regAddr == sdl_pkg::REG_RX_FIFO) begin
                  cfg_nxt[p].rxDepth = mgmt.data[sdl_pkg::BIT_RX_DEPTH_HI:
                                                 sdl_pkg::BIT_RX_DEPTH_LO];
               end
            end
         end

         always_ff @(posedge mclk or negedge nrst) begin
            if (!nrst) begin
               cfg_r[p].mediaFiber <= sdl_pkg::RST_MEDIA_FIBER;
               cfg_r[p].rxDepth <= sdl_pkg::RST_RX_DEPTH;
            end else begin
               cfg_r[p] <= cfg_nxt[p];
            end
         end
      end
   endgenerate

   assign portCfg = cfg_r;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   logic [sdl_pkg::PORT_COUNT-1:0] fiberVec;
   logic [2*sdl_pkg::PORT_COUNT-1:0] depthVec;

   always_comb begin
      fiberVec = '0;
      depthVec = '0;
      for (int i = 0; i < sdl_pkg::PORT_COUNT; i++) begin
         fiberVec[i] = cfg_r[i].mediaFiber;
         depthVec[2*i +: 2] = cfg_r[i].rxDepth;
      end
   end

   AST_MEDIA_LOAD: assert property (@(posedge mclk) disable iff (!nrst)
      (state_r == sdl_pkg::SDL_LOAD) |=> (fiberVec == {8{$past(mediaStable)}}))
      else $error("Media default not copied to all ports.");

   AST_MEDIA_UNIFORM: assert property (@(posedge mclk) disable iff (!nrst)
      $rose(state_r == sdl_pkg::SDL_RUN) |-> (fiberVec == 8'h00 || fiberVec == 8'hff))
      else $error("Ports disagree on media after load.");

   AST_DEPTH_LOAD: assert property (@(posedge mclk) disable iff (!nrst)
      (state_r == sdl_pkg::SDL_LOAD) |=> (depthVec == {8{$past(depthStable)}}))
      else $error("FIFO depth default not copied to all ports.");

   AST_WRITE_MEDIA: assert property (@(posedge mclk) disable iff (!nrst)
      (state_r == sdl_pkg::SDL_RUN && mgmt.wrEn && mgmt.regAddr == sdl_pkg::REG_PORT_CFG)
      |=> (cfg_r[$past(mgmt.port)].mediaFiber == $past(mgmt.data[0])))
      else $error("Media write did not replace default.");

   AST_PINS_RELEASED: assert property (@(posedge mclk) disable iff (!nrst)
      (state_r != sdl_pkg::SDL_RUN) |-> (rxErrOe_r == 2'h0))
      else $error("Receive-error pins driven before strap capture.");

   AST_PINS_DRIVEN: assert property (@(posedge mclk) disable iff (!nrst)
      (state_r == sdl_pkg::SDL_RUN) |-> (rxErrOe_r == 2'h3))
      else $error("Receive-error pins not driven after strap capture.");

   AST_PIN_FOLLOWS: assert property (@(posedge mclk) disable iff (!nrst)
      (state_r == sdl_pkg::SDL_RUN) |=> (rxErrOut_r == $past(rxErrCore)))
      else $error("Receive-error pin does not follow the core.");

   AST_DEPTH_WRITE: assert property (@(posedge mclk) disable iff (!nrst)
      (state_r == sdl_pkg::SDL_RUN && mgmt.wrEn && mgmt.regAddr == sdl_pkg::REG_RX_FIFO)
      |=> (cfg_r[$past(mgmt.port)].rxDepth == $past(mgmt.data[15:14])))
      else $error("Depth write did not replace default.");

   AST_LOW_DEFAULT: assert property (@(posedge mclk) disable iff (!nrst)
      (state_r == sdl_pkg::SDL_LOAD && depthStable == 2'h0 && !mediaStable)
      |=> (depthVec == 16'h0000 && fiberVec == 8'h00))
      else $error("Low straps did not give low defaults.");

   AST_NO_RELOAD: assert property (@(posedge mclk) disable iff (!nrst)
      (state_r == sdl_pkg::SDL_RUN && !mgmt.wrEn) |=> $stable(cfg_r))
      else $error("Defaults changed without a write after capture.");

   AST_CAPTURE_ONCE: assert property (@(posedge mclk) disable iff (!nrst)
      (state_r == sdl_pkg::SDL_RUN) |=> (state_r == sdl_pkg::SDL_RUN))
      else $error("Sequencer left the run state without a reset.");

   AST_EARLY_WRITE_DROPPED: assert property (@(posedge mclk) disable iff (!nrst)
      (state_r == sdl_pkg::SDL_WAIT) |=> (fiberVec == 8'h00 && depthVec == 16'h0000))
      else $error("Configuration changed before strap capture.");

endmodule // strap_default_loader

// file: tb/sdl_strap_board.sv
// Board model for the strap pins: pull resistors and the shared wires.
// Assumes the loader drives the shared wires only while its enable is high.
`timescale 1ns/1ps
module sdl_strap_board (
   input wire logic pullMedia,
   input wire logic pullHi,
   input wire logic pullLo,
   input wire logic [1:0] pinOut,
   input wire logic [1:0] pinOe,
   output logic mediaPin,
   output logic depthHiPin,
   output logic depthLoPin
);
   // ----------------------------------------------------------------
   // Wire resolution
   // ----------------------------------------------------------------
   // An unfitted pull-up leaves the pad pull-down in charge, so the level is 0.
   assign mediaPin = pullMedia;
   assign depthHiPin = pinOe[1] ? pinOut[1] : pullHi;
   assign depthLoPin = pinOe[0] ? pinOut[0] : pullLo;
endmodule // sdl_strap_board

// file: tb/strap_default_loader_bench.sv
// Self-checking bench for the strap default loader.
// Assumes the board model above and reset hold of six cycles.
`timescale 1ns/1ps
module strap_default_loader_bench;
   logic mclk = 1'b0;
   logic nrst = 1'b0;
   logic pullMedia = 1'b0;
   logic pullHi = 1'b0;
   logic pullLo = 1'b0;
   logic [1:0] rxErrCore = 2'h0;
   logic mediaPin, depthHiPin, depthLoPin;
   logic [1:0] rxErrPinOut, rxErrPinOe;
   sdl_pkg::sdl_mgmt_s mgmt = '0;
   sdl_pkg::sdl_port_cfg_s [sdl_pkg::PORT_COUNT-1:0] portCfg;
   int err_count = 0;
   int cmp_count = 0;
   int cycles = 0;

   always #5 mclk = ~mclk;

   strap_default_loader strap_default_loader_inst (
      .mclk(mclk), .nrst(nrst), .globalMediaSelectStrap(mediaPin),
      .rxDepthStrapHi(depthHiPin), .rxDepthStrapLo(depthLoPin),
      .rxErrCore(rxErrCore), .rxErrPinOut(rxErrPinOut), .rxErrPinOe(rxErrPinOe),
      .mgmt(mgmt), .portCfg(portCfg));

   sdl_strap_board sdl_strap_board_inst (
      .pullMedia(pullMedia), .pullHi(pullHi), .pullLo(pullLo),
      .pinOut(rxErrPinOut), .pinOe(rxErrPinOe), .mediaPin(mediaPin),
      .depthHiPin(depthHiPin), .depthLoPin(depthLoPin));

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic report_and_stop();
      $display("checks %0d, mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // The ceiling is far above the roughly 134 cycles the scenarios need.
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 5000) begin
         err_count++;
         report_and_stop();
      end
   end

   task automatic step(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask

   task automatic check_all(input logic [2:0] exp);
      for (int p = 0; p < sdl_pkg::PORT_COUNT; p++) begin
         check(16'(portCfg[p]), 16'(exp));
      end
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   // Reset with given pulls; a write offered before the run state must be lost.
   task automatic load_straps(input logic m, input logic h, input logic l);
      nrst = 1'b0;
      pullMedia = m;
      pullHi = h;
      pullLo = l;
      step(6);
      check(16'(rxErrPinOe), 16'h0);
      check_all(3'h0);
      nrst = 1'b1;
      mgmt = '{wrEn: 1'b1, port: 3'h0, regAddr: 5'h10, data: {16{~m}}};
      step(3);
      check(16'(rxErrPinOe), 16'h0);
      step(1);
      mgmt.wrEn = 1'b0;
      step(2);
      check(16'(rxErrPinOe), 16'h3);
      check_all({m, h, l});
   endtask

   task automatic wr(input logic [2:0] p, input logic [4:0] a, input logic [15:0] d);
      mgmt = '{wrEn: 1'b1, port: p, regAddr: a, data: d};
      step(1);
      mgmt.wrEn = 1'b0;
      step(1);
   endtask

   // Pin activity after the load must not disturb the defaults.
   task automatic late_pins();
      pullMedia = ~pullMedia;
      pullHi = ~pullHi;
      pullLo = ~pullLo;
      rxErrCore = 2'h2;
      step(1);
      check(16'(rxErrPinOut), 16'h2);
      rxErrCore = 2'h1;
      step(1);
      check(16'(rxErrPinOut), 16'h1);
      step(4);
      check_all({~pullMedia, ~pullHi, ~pullLo});
   endtask

   // Written bits replace the loaded defaults, other fields and ports untouched.
   task automatic writes();
      wr(3'h3, 5'h10, 16'h0000);
      wr(3'h5, 5'h12, 16'h4000);
      wr(3'h5, 5'h11, 16'hffff);
      wr(3'h6, 5'h10, 16'hfffe);
      check(16'(portCfg[3]), 16'h2);
      check(16'(portCfg[5]), 16'h5);
      check(16'(portCfg[6]), 16'h2);
      check(16'(portCfg[0]), 16'h6);
   endtask

   initial begin
      for (int i = 0; i < 8; i++) begin
         load_straps(i[2], i[1], i[0]);
      end
      load_straps(1'b1, 1'b1, 1'b0);
      late_pins();
      load_straps(1'b1, 1'b1, 1'b0);
      writes();
      report_and_stop();
   end
endmodule // strap_default_loader_bench
